// >>> src/scs_pkg.sv
package scs_pkg;
   // Register byte offsets
   localparam logic [7:0] OFS_PRI_MODE   = 8'h00;
   localparam logic [7:0] OFS_SEC_MODE   = 8'h04;
   localparam logic [7:0] OFS_CLAMP      = 8'h08;
   localparam logic [7:0] OFS_SPD_SCALE  = 8'h0c;
   localparam logic [7:0] OFS_TRQ_SCALE  = 8'h10;
   localparam logic [7:0] OFS_OFFSET1    = 8'h14;
   localparam logic [7:0] OFS_OFFSET2    = 8'h18;
   localparam logic [7:0] OFS_DEADBAND1  = 8'h1c;
   localparam logic [7:0] OFS_DEADBAND2  = 8'h20;
   localparam logic [7:0] OFS_LOWPASS1   = 8'h24;
   localparam logic [7:0] OFS_LOWPASS2   = 8'h28;
   localparam logic [7:0] OFS_SRC_SEL    = 8'h2c;
   localparam logic [7:0] OFS_ACCEL      = 8'h30;
   localparam logic [7:0] OFS_DECEL      = 8'h34;
   localparam logic [7:0] OFS_INT_LIMIT  = 8'h38;
   localparam logic [7:0] OFS_PRESET0    = 8'h40;
   localparam logic [7:0] OFS_SPEED_CMD  = 8'h60;
   localparam logic [7:0] OFS_TORQUE_CMD = 8'h64;
   localparam logic [7:0] OFS_STATUS     = 8'h68;
   // Mode codes
   localparam logic [4:0] MODE_1  = 5'h01;
   localparam logic [4:0] MODE_2  = 5'h02;
   localparam logic [4:0] MODE_7  = 5'h07;
   localparam logic [4:0] MODE_ANLG = 5'h0b;
   localparam logic [4:0] MODE_MS = 5'h0f;
   localparam logic [4:0] MODE_COM = 5'h15;
   // Reset values
   localparam logic [4:0]  RST_PRI_MODE  = MODE_7;
   localparam logic [4:0]  RST_SEC_MODE  = MODE_COM;
   localparam logic [1:0]  RST_CLAMP     = 2'h2;
   localparam logic [6:0]  RST_SPD_SCALE = 7'h32;
   localparam logic [11:0] RST_TRQ_SCALE = 12'h3e8;
   localparam logic [14:0] RST_LOWPASS   = 15'h03e8;
   localparam logic [22:0] RST_RATE      = 23'h0186a0;
   // Limits
   localparam int          MAX_SPD_SCALE = 100;
   localparam int          MAX_TRQ_SCALE = 3000;
   localparam int          MAX_OFFSET    = 10000;
   localparam int          MAX_LOWPASS   = 20000;
   localparam int          MIN_RATE      = 167;
   localparam int          MAX_RATE      = 5000000;
   localparam int          NUM_PRESETS   = 8;
   // Timing: filter and ramp update rate
   localparam int          CLK_HZ        = 125000000;
   localparam int          TICK_HZ       = 10000;
   localparam int          TICK_CYC      = CLK_HZ / TICK_HZ;
   // Full-scale ADC code corresponds to 10000 mV
   localparam int          FULL_MV       = 10000;
   // 2*pi*0.1Hz/TICK_HZ scaled by 2^26
   localparam int          ALPHA_NUM     = 4217;
endpackage

// >>> src/scs_speed_command_select.sv
// Our own choices: the address map and the APB slave port.
`timescale 1ns/1ps
// How it works
// R1 - Mode code 11 runs analog speed mode from the bipolar speed input.
// R2 - Mode code 21 takes speed from the communication or program command.
// R3 - Mode code 15, once enabled, runs the preset picked by three select inputs.
// R4 - Exactly eight preset speed segments are addressable.
// R5 - Mode settings accept only 1,2,7,11,15,21; defaults 7 and 21.
// R6 - Two 12-bit channels: first gives speed, second gives torque.
// R7 - Speed scale is rps at 10 V, 0 to 100, default 50.
// R8 - Torque scale is 0.1 percent at 10 V, 0 to 3000, default 1000.
// R9 - Per-channel signed offset in mV, within 10000, default 0.
// R10 - Per-channel dead band in mV, 0 to 255, default 0.
// R11 - Per-channel low-pass cutoff in 0.1 Hz, 0 to 20000, default 1000.
// R12 - Source 0 picks internal speed limit, 1 picks analog command.
// R13 - Selecting analog speed mode forces the source setting to 1.
// R14 - Preset and analog modes ramp with accel and decel rates, default 100000.
// R15 - Clamp type accepts 1 or 2, default 2.
// R16 - Inputs within the dead band count as exactly zero.
// R17 - Each channel has a digital low-pass filter following its cutoff.
// R18 - Order: offset, dead band, filter, then scale.
module scs_speed_command_select #(
   parameter int TICK_CYCLES = scs_pkg::TICK_CYC
) (
   // APB
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // Host inputs
   input  wire logic [11:0] speed_analog_in,
   input  wire logic [11:0] torque_analog_in,
   input  wire logic        speed_select_bit0,
   input  wire logic        speed_select_bit1,
   input  wire logic        speed_select_bit2,
   input  wire logic        drive_enable,
   input  wire logic        mode_switch,
   input  wire logic [31:0] comm_speed,
   // Commands out, speed in 0.001 rps, torque in 0.1 percent
   output logic      [31:0] speed_cmd,
   output logic      [31:0] speed_limit,
   output logic      [31:0] torque_cmd,
   output logic      [4:0]  active_mode,
   output logic      [1:0]  clamp_type_code
);

   function automatic logic mode_ok(input logic [31:0] v);
      return v == 32'(scs_pkg::MODE_1) || v == 32'(scs_pkg::MODE_2)
          || v == 32'(scs_pkg::MODE_7) || v == 32'(scs_pkg::MODE_ANLG)
          || v == 32'(scs_pkg::MODE_MS) || v == 32'(scs_pkg::MODE_COM);
   endfunction

   function automatic logic signed [15:0] dead(input logic signed [15:0] x,
                                                input logic [7:0] db);
      logic signed [15:0] m;
      m = (x < 0) ? -x : x;
      return (m <= $signed({8'h00, db})) ? 16'sh0000 : x;
   endfunction

   function automatic logic [16:0] alpha(input logic [14:0] f);
      logic [31:0] a;
      a = ({17'h00000, f} * 32'(scs_pkg::ALPHA_NUM)) >> 10;
      return (a > 32'h0001_0000) ? 17'h10000 : a[16:0];
   endfunction

   function automatic logic signed [15:0] to_mv(input logic [11:0] c);
      logic signed [31:0] p;
      p = $signed({{20{c[11]}}, c}) * scs_pkg::FULL_MV;
      return 16'(p >>> 11);
   endfunction

   // Settings
   logic        [4:0]  primary_mode_code;
   logic        [4:0]  secondary_control_mode;
   logic        [6:0]  speed_scale_code;
   logic        [11:0] torque_scale_code;
   logic signed [15:0] offset_code [2];
   logic        [7:0]  deadband_code [2];
   logic        [14:0] lowpass_code [2];
   logic               speed_source_code;
   logic        [22:0] accel_rate_code;
   logic        [22:0] decel_rate_code;
   logic        [31:0] int_limit;
   logic signed [31:0] preset_speed [scs_pkg::NUM_PRESETS];

   // APB decode
   wire         setup_phase = psel && !penable;
   wire         wr_take     = psel && penable && pwrite;
   wire  [31:0] wd          = pwdata;
   wire  signed [31:0] wds  = $signed(pwdata);
   wire         is_preset   = paddr[7:5] == scs_pkg::OFS_PRESET0[7:5] && paddr[1:0] == 2'b00;
   wire  [2:0]  preset_idx  = paddr[4:2];
   wire         ok_pri   = paddr == scs_pkg::OFS_PRI_MODE && mode_ok(wd); // R5
   wire         ok_sec   = paddr == scs_pkg::OFS_SEC_MODE && mode_ok(wd); // R5
   wire         ok_clamp = paddr == scs_pkg::OFS_CLAMP && (wd == 32'h1 || wd == 32'h2); // R15
   wire         ok_sscl  = paddr == scs_pkg::OFS_SPD_SCALE && wd <= 32'(scs_pkg::MAX_SPD_SCALE); // R7
   wire         ok_tscl  = paddr == scs_pkg::OFS_TRQ_SCALE && wd <= 32'(scs_pkg::MAX_TRQ_SCALE); // R8
   wire         ofs_rng  = wds >= -scs_pkg::MAX_OFFSET && wds <= scs_pkg::MAX_OFFSET; // R9
   wire         ok_ofs1  = paddr == scs_pkg::OFS_OFFSET1 && ofs_rng;
   wire         ok_ofs2  = paddr == scs_pkg::OFS_OFFSET2 && ofs_rng;
   wire         ok_db1   = paddr == scs_pkg::OFS_DEADBAND1 && wd <= 32'h0000_00ff; // R10
   wire         ok_db2   = paddr == scs_pkg::OFS_DEADBAND2 && wd <= 32'h0000_00ff; // R10
   wire         lp_rng   = wd <= 32'(scs_pkg::MAX_LOWPASS); // R11
   wire         ok_lp1   = paddr == scs_pkg::OFS_LOWPASS1 && lp_rng;
   wire         ok_lp2   = paddr == scs_pkg::OFS_LOWPASS2 && lp_rng;
   wire         ok_src   = paddr == scs_pkg::OFS_SRC_SEL && wd <= 32'h1; // R12
   wire         rate_rng = wd >= 32'(scs_pkg::MIN_RATE) && wd <= 32'(scs_pkg::MAX_RATE); // R14
   wire         ok_acc   = paddr == scs_pkg::OFS_ACCEL && rate_rng;
   wire         ok_dec   = paddr == scs_pkg::OFS_DECEL && rate_rng;
   wire         ok_lim   = paddr == scs_pkg::OFS_INT_LIMIT;
   wire         wr_ok    = ok_pri | ok_sec | ok_clamp | ok_sscl | ok_tscl | ok_ofs1 | ok_ofs2
                         | ok_db1 | ok_db2 | ok_lp1 | ok_lp2 | ok_src | ok_acc | ok_dec
                         | ok_lim | is_preset;
   wire         rd_hit   = paddr <= scs_pkg::OFS_STATUS && paddr[1:0] == 2'b00
                         && paddr != 8'h3c;
   wire         mode_anlg = active_mode == scs_pkg::MODE_ANLG;

   // Mode and source
   wire  [4:0]  next_mode = mode_switch ? secondary_control_mode : primary_mode_code;

   // Analog conditioning
   wire  [11:0] raw [2];
   assign raw[0] = speed_analog_in;  // R6
   assign raw[1] = torque_analog_in; // R6
   logic signed [15:0] corr [2];
   logic signed [15:0] dz [2];
   logic signed [31:0] filt [2];
   logic signed [48:0] filt_step [2];
   logic signed [15:0] filt_mv [2];
   for (genvar i = 0; i < 2; i++) begin : g_chan
      assign corr[i] = 16'(to_mv(raw[i]) - offset_code[i]);          // R18
      assign dz[i]   = dead(corr[i], deadband_code[i]);                 // R16
      assign filt_step[i] = ($signed({dz[i], 16'h0000}) - 49'(filt[i]))
                          * $signed({1'b0, alpha(lowpass_code[i])}); // R17
      assign filt_mv[i] = 16'(filt[i] >>> 16);
   end

   // Speed target in 0.001 rps
   logic signed [31:0] mv_speed_cmd;
   logic signed [31:0] mv_torque_cmd;
   assign mv_speed_cmd  = 32'((48'(filt_mv[0]) * $signed({41'h0, speed_scale_code})) / 10); // R7
   assign mv_torque_cmd = 32'((48'(filt_mv[1]) * $signed({36'h0, torque_scale_code}))
                        / scs_pkg::FULL_MV); // R8
   wire  [2:0]  sel = {speed_select_bit2, speed_select_bit1, speed_select_bit0}; // R4
   logic signed [31:0] target;
   assign target = (active_mode == scs_pkg::MODE_ANLG) ? mv_speed_cmd                   // R1
                 : (active_mode == scs_pkg::MODE_COM) ? $signed(comm_speed)             // R2
                 : (active_mode == scs_pkg::MODE_MS && drive_enable) ? preset_speed[sel] // R3
                 : 32'sh0;
   wire         ramped = active_mode == scs_pkg::MODE_ANLG || active_mode == scs_pkg::MODE_MS;

   // Ramp, held in units of 0.001 rps times TICK_HZ
   logic signed [39:0] ramp;
   logic        [15:0] tick_cnt;
   wire         tick   = tick_cnt == 16'(TICK_CYCLES - 1);
   wire  signed [39:0] goal = 40'(target) * 40'(scs_pkg::TICK_HZ);
   wire  [22:0] up_rate = (ramp >= 0) ? accel_rate_code : decel_rate_code; // R14
   wire  [22:0] dn_rate = (ramp <= 0) ? accel_rate_code : decel_rate_code; // R14
   wire  signed [39:0] up_val = ramp + 40'(up_rate);
   wire  signed [39:0] dn_val = ramp - 40'(dn_rate);
   logic signed [39:0] next_ramp;
   assign next_ramp = !ramped ? goal
                    : !tick ? ramp
                    : (ramp < goal) ? ((up_val > goal) ? goal : up_val)
                    : (ramp > goal) ? ((dn_val < goal) ? goal : dn_val)
                    : ramp;
   wire  signed [31:0] next_speed = 32'(ramp / scs_pkg::TICK_HZ);
   wire  [31:0] abs_anlg = (mv_speed_cmd < 0) ? 32'(-mv_speed_cmd) : mv_speed_cmd;

   // Read mux
   logic [31:0] rd_val;
   always_comb begin
      rd_val = 32'h0;
      if (is_preset) begin
         rd_val = preset_speed[preset_idx];
      end else begin
         unique case (paddr)
            scs_pkg::OFS_PRI_MODE:   rd_val = 32'(primary_mode_code);
            scs_pkg::OFS_SEC_MODE:   rd_val = 32'(secondary_control_mode);
            scs_pkg::OFS_CLAMP:      rd_val = 32'(clamp_type_code);
            scs_pkg::OFS_SPD_SCALE:  rd_val = 32'(speed_scale_code);
            scs_pkg::OFS_TRQ_SCALE:  rd_val = 32'(torque_scale_code);
            scs_pkg::OFS_OFFSET1:    rd_val = 32'(offset_code[0]);
            scs_pkg::OFS_OFFSET2:    rd_val = 32'(offset_code[1]);
            scs_pkg::OFS_DEADBAND1:  rd_val = 32'(deadband_code[0]);
            scs_pkg::OFS_DEADBAND2:  rd_val = 32'(deadband_code[1]);
            scs_pkg::OFS_LOWPASS1:   rd_val = 32'(lowpass_code[0]);
            scs_pkg::OFS_LOWPASS2:   rd_val = 32'(lowpass_code[1]);
            scs_pkg::OFS_SRC_SEL:    rd_val = 32'(speed_source_code);
            scs_pkg::OFS_ACCEL:      rd_val = 32'(accel_rate_code);
            scs_pkg::OFS_DECEL:      rd_val = 32'(decel_rate_code);
            scs_pkg::OFS_INT_LIMIT:  rd_val = int_limit;
            scs_pkg::OFS_SPEED_CMD:  rd_val = speed_cmd;
            scs_pkg::OFS_TORQUE_CMD: rd_val = torque_cmd;
            scs_pkg::OFS_STATUS:     rd_val = {26'h0, ramp == goal, active_mode};
            default:                 rd_val = 32'h0;
         endcase
      end
   end

   // Bus answer: zero wait, data and error staged in setup
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready  <= 1'b0;
         prdata  <= 32'h0;
         pslverr <= 1'b0;
      end else begin
         pready <= 1'b1;
         if (setup_phase) begin
            prdata  <= pwrite ? 32'h0 : rd_val;
            pslverr <= pwrite ? !wr_ok : !rd_hit;
         end
      end
   end

   // Settings write
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         primary_mode_code      <= scs_pkg::RST_PRI_MODE;
         secondary_control_mode <= scs_pkg::RST_SEC_MODE;
         clamp_type_code        <= scs_pkg::RST_CLAMP;
         speed_scale_code       <= scs_pkg::RST_SPD_SCALE;
         torque_scale_code      <= scs_pkg::RST_TRQ_SCALE;
         offset_code            <= '{16'sh0, 16'sh0};
         deadband_code          <= '{8'h0, 8'h0};
         lowpass_code           <= '{scs_pkg::RST_LOWPASS, scs_pkg::RST_LOWPASS};
         speed_source_code      <= 1'b0;
         accel_rate_code        <= scs_pkg::RST_RATE;
         decel_rate_code        <= scs_pkg::RST_RATE;
         int_limit              <= 32'h0;
         preset_speed           <= '{default: 32'sh0};
      end else begin
         if (wr_take && ok_pri)   primary_mode_code      <= wd[4:0];
         if (wr_take && ok_sec)   secondary_control_mode <= wd[4:0];
         if (wr_take && ok_clamp) clamp_type_code        <= wd[1:0];
         if (wr_take && ok_sscl)  speed_scale_code       <= wd[6:0];
         if (wr_take && ok_tscl)  torque_scale_code      <= wd[11:0];
         if (wr_take && ok_ofs1)  offset_code[0]         <= wd[15:0];
         if (wr_take && ok_ofs2)  offset_code[1]         <= wd[15:0];
         if (wr_take && ok_db1)   deadband_code[0]       <= wd[7:0];
         if (wr_take && ok_db2)   deadband_code[1]       <= wd[7:0];
         if (wr_take && ok_lp1)   lowpass_code[0]        <= wd[14:0];
         if (wr_take && ok_lp2)   lowpass_code[1]        <= wd[14:0];
         if (wr_take && ok_acc)   accel_rate_code        <= wd[22:0];
         if (wr_take && ok_dec)   decel_rate_code        <= wd[22:0];
         if (wr_take && ok_lim)   int_limit              <= wd;
         if (wr_take && is_preset) preset_speed[preset_idx] <= wds;
         // Analog mode wins over a software write of the source
         if (next_mode == scs_pkg::MODE_ANLG)          speed_source_code <= 1'b1; // R13
         else if (wr_take && ok_src)                   speed_source_code <= wd[0];
      end
   end

   // Datapath
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tick_cnt    <= 16'h0;
         filt        <= '{32'sh0, 32'sh0};
         ramp        <= 40'sh0;
         active_mode <= scs_pkg::RST_PRI_MODE;
         speed_cmd   <= 32'h0;
         torque_cmd  <= 32'h0;
         speed_limit <= 32'h0;
      end else begin
         tick_cnt    <= tick ? 16'h0 : tick_cnt + 16'h1;
         if (tick) begin
            filt[0] <= filt[0] + 32'(filt_step[0] >>> 16); // R17
            filt[1] <= filt[1] + 32'(filt_step[1] >>> 16); // R17
         end
         ramp        <= next_ramp; // R14
         active_mode <= next_mode;
         speed_cmd   <= next_speed;
         torque_cmd  <= mv_torque_cmd;
         speed_limit <= speed_source_code ? abs_anlg : int_limit; // R12
      end
   end

   // Checks
   property p_mode_legal;
      @(posedge pclk) disable iff (!presetn)
      mode_ok(32'(primary_mode_code)) && mode_ok(32'(secondary_control_mode));
   endproperty
   a_mode_legal: assert property (p_mode_legal) else $error("illegal mode code held"); // R5

   property p_bad_mode;
      @(posedge pclk) disable iff (!presetn)
      (setup_phase && pwrite && paddr == scs_pkg::OFS_PRI_MODE && !mode_ok(wd))
      ##1 (wr_take && $stable(paddr)) |=> pslverr && $stable(primary_mode_code);
   endproperty
   a_bad_mode: assert property (p_bad_mode) else $error("bad mode write accepted"); // R5

   property p_force_src;
      @(posedge pclk) disable iff (!presetn)
      next_mode == scs_pkg::MODE_ANLG |=> speed_source_code;
   endproperty
   a_force_src: assert property (p_force_src) else $error("analog source not forced"); // R13

   property p_clamp;
      @(posedge pclk) disable iff (!presetn)
      clamp_type_code == 2'h1 || clamp_type_code == 2'h2;
   endproperty
   a_clamp: assert property (p_clamp) else $error("clamp type out of range"); // R15

   property p_dead;
      @(posedge pclk) disable iff (!presetn)
      ((corr[0] < 0 ? -corr[0] : corr[0]) <= $signed({8'h00, deadband_code[0]})) |-> dz[0] == 0;
   endproperty
   a_dead: assert property (p_dead) else $error("dead band input not zero"); // R16

   property p_preset;
      @(posedge pclk) disable iff (!presetn)
      mode_anlg == 1'b0 && active_mode == scs_pkg::MODE_MS && drive_enable
      |-> target == preset_speed[sel];
   endproperty
   a_preset: assert property (p_preset) else $error("preset not selected"); // R3

   sequence s_climb;
      ramped && tick && ramp < goal;
   endsequence
   property p_ramp_step;
      @(posedge pclk) disable iff (!presetn)
      s_climb ##0 ramped |=> (ramp - $past(ramp)) <= 40'(scs_pkg::MAX_RATE) && ramp > $past(ramp);
   endproperty
   a_ramp_step: assert property (p_ramp_step) else $error("ramp step wrong"); // R14

   property p_comm;
      @(posedge pclk) disable iff (!presetn)
      active_mode == scs_pkg::MODE_COM ##1 active_mode == scs_pkg::MODE_COM && $stable(comm_speed)
      |=> speed_cmd == $past(comm_speed, 2);
   endproperty
   a_comm: assert property (p_comm) else $error("comm speed not followed"); // R2

endmodule

// >>> sim/scs_host_model.sv
`timescale 1ns/1ps
module scs_host_model (
   // Clock and reset
   input  wire logic               pclk,
   input  wire logic               presetn,
   // Requests from the bench
   input  wire logic [2:0]         req_index,
   input  wire logic               req_enable,
   input  wire logic               req_switch,
   input  wire logic signed [15:0] req_spd_mv,
   input  wire logic signed [15:0] req_trq_mv,
   input  wire logic [31:0]        req_comm,
   // Pins toward the drive
   output logic [11:0]             speed_analog_in,
   output logic [11:0]             torque_analog_in,
   output logic                    speed_select_bit0,
   output logic                    speed_select_bit1,
   output logic                    speed_select_bit2,
   output logic                    drive_enable,
   output logic                    mode_switch,
   output logic [31:0]             comm_speed
);
   // Host converts millivolts to converter codes, 2048 codes per 10 V
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         speed_analog_in   <= 12'h000;
         torque_analog_in  <= 12'h000;
         {speed_select_bit2, speed_select_bit1, speed_select_bit0} <= 3'h0;
         drive_enable      <= 1'b0;
         mode_switch       <= 1'b0;
         comm_speed        <= 32'h0;
      end else begin
         speed_analog_in   <= 12'(int'(req_spd_mv) * 2048 / 10000);
         torque_analog_in  <= 12'(int'(req_trq_mv) * 2048 / 10000);
         {speed_select_bit2, speed_select_bit1, speed_select_bit0} <= req_index;
         drive_enable      <= req_enable;
         mode_switch       <= req_switch;
         comm_speed        <= req_comm;
      end
   end
endmodule

// >>> sim/tb_speed_command_select.sv
`timescale 1ns/1ps
module tb_speed_command_select;
   logic               pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [7:0]         paddr;
   logic [31:0]        pwdata, prdata, rd_data, speed_cmd, speed_limit, torque_cmd, comm_speed;
   logic               rd_err, b0, b1, b2, drive_enable, mode_switch;
   logic [11:0]        spd_in, trq_in;
   logic [4:0]         active_mode;
   logic [1:0]         clamp_type_code;
   logic [2:0]         req_index;
   logic               req_enable, req_switch;
   logic signed [15:0] req_spd_mv, req_trq_mv;
   logic [31:0]        req_comm;
   int                 failures, cmp_count;
   logic [31:0]        good[6] = '{32'd1, 32'd2, 32'd7, 32'd11, 32'd15, 32'd21};
   logic [31:0]        bad[4]  = '{32'd0, 32'd3, 32'd12, 32'd22};
   logic [7:0]         oor_a[7] = '{8'h0c, 8'h10, 8'h14, 8'h1c, 8'h24, 8'h30, 8'h34};
   logic [31:0]        oor_d[7] = '{32'd101, 32'd3001, 32'd10001, 32'd256, 32'd20001,
                                    32'd166, 32'd5000001};

   scs_speed_command_select #(.TICK_CYCLES(10)) scs_speed_command_select_i (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .speed_analog_in(spd_in), .torque_analog_in(trq_in), .speed_select_bit0(b0),
      .speed_select_bit1(b1), .speed_select_bit2(b2), .drive_enable(drive_enable),
      .mode_switch(mode_switch), .comm_speed(comm_speed), .speed_cmd(speed_cmd),
      .speed_limit(speed_limit), .torque_cmd(torque_cmd), .active_mode(active_mode),
      .clamp_type_code(clamp_type_code));

   scs_host_model scs_host_model_i (
      .pclk(pclk), .presetn(presetn), .req_index(req_index), .req_enable(req_enable),
      .req_switch(req_switch), .req_spd_mv(req_spd_mv), .req_trq_mv(req_trq_mv),
      .req_comm(req_comm), .speed_analog_in(spd_in), .torque_analog_in(trq_in),
      .speed_select_bit0(b0), .speed_select_bit1(b1), .speed_select_bit2(b2),
      .drive_enable(drive_enable), .mode_switch(mode_switch), .comm_speed(comm_speed));

   initial begin
      pclk = 1'b0;
      forever #4 pclk = ~pclk;
   end

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         failures++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   // Preset table: ascending magnitudes with alternating sign
   function automatic logic [31:0] preset_val(input int i);
      return (i % 2) ? -32'(100 * (i + 1)) : 32'(100 * (i + 1));
   endfunction

   // One APB transfer; holds the request until pready is sampled high
   task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 100);
      if (n >= 100) failures++;
      rd_data = prdata;
      rd_err  = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr_chk(input logic [7:0] a, input logic [31:0] d, input logic e);
      xfer(a, 1'b1, d);
      chk({31'h0, rd_err}, {31'h0, e});
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
      xfer(a, 1'b0, 32'h0);
      chk(rd_data, exp);
   endtask

   task automatic wrap_up;
      $display("comparisons %0d mismatches %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   initial begin
      repeat (20000) @(posedge pclk);
      failures++;
      wrap_up;
   end

   initial begin
      {psel, penable, pwrite, paddr, pwdata} = '0;
      {req_index, req_enable, req_switch, req_spd_mv, req_trq_mv, req_comm} = '0;
      failures = 0;
      cmp_count = 0;
      presetn = 1'b0;
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      chk(32'(active_mode), 32'd7);
      chk(32'(clamp_type_code), 32'd2);
      rd_chk(8'h00, 32'd7);
      rd_chk(8'h04, 32'd21);
      rd_chk(8'h0c, 32'd50);
      rd_chk(8'h10, 32'd1000);
      rd_chk(8'h18, 32'd0);
      rd_chk(8'h20, 32'd0);
      rd_chk(8'h24, 32'd1000);
      rd_chk(8'h2c, 32'd0);
      rd_chk(8'h34, 32'd100000);
      $display("reset values done");
      for (int m = 0; m < 2; m++) begin
         foreach (bad[i]) wr_chk(8'(m * 4), bad[i], 1'b1);
         foreach (good[i]) begin
            wr_chk(8'(m * 4), good[i], 1'b0);
            rd_chk(8'(m * 4), good[i]);
         end
      end
      wr_chk(8'h00, 32'd7, 1'b0);
      wr_chk(8'h08, 32'd3, 1'b1);
      wr_chk(8'h08, 32'd1, 1'b0);
      @(posedge pclk);
      chk(32'(clamp_type_code), 32'd1);
      foreach (oor_a[i]) wr_chk(oor_a[i], oor_d[i], 1'b1);
      wr_chk(8'h14, 32'hffffd8f0, 1'b0);
      rd_chk(8'h14, 32'hffffd8f0);
      wr_chk(8'h14, 32'h0, 1'b0);
      rd_chk(8'h3c, 32'h0);
      chk({31'h0, rd_err}, 32'h1);
      wr_chk(8'h60, 32'h1, 1'b1);
      $display("settings done");
      req_comm <= 32'hfffff830;
      wr_chk(8'h00, 32'd21, 1'b0);
      repeat (5) @(posedge pclk);
      chk(speed_cmd, 32'hfffff830);
      chk(32'(active_mode), 32'd21);
      wr_chk(8'h00, 32'd7, 1'b0);
      req_switch <= 1'b1;
      repeat (4) @(posedge pclk);
      chk(32'(active_mode), 32'd21);
      req_switch <= 1'b0;
      $display("command mode done");
      wr_chk(8'h30, 32'd5000000, 1'b0);
      wr_chk(8'h34, 32'd5000000, 1'b0);
      for (int i = 0; i < 8; i++)
         wr_chk(8'(8'h40 + 4 * i), preset_val(i), 1'b0);
      wr_chk(8'h00, 32'd15, 1'b0);
      req_enable <= 1'b1;
      for (int i = 0; i < 8; i++) begin
         req_index <= 3'(i);
         repeat (80) @(posedge pclk);
         chk(speed_cmd, preset_val(i));
      end
      rd_chk(8'h60, 32'hfffffce0);
      req_enable <= 1'b0;
      repeat (80) @(posedge pclk);
      chk(speed_cmd, 32'h0);
      $display("preset mode done");
      wr_chk(8'h00, 32'd7, 1'b0);
      wr_chk(8'h38, 32'd4321, 1'b0);
      wr_chk(8'h2c, 32'd0, 1'b0);
      repeat (3) @(posedge pclk);
      chk(speed_limit, 32'd4321);
      wr_chk(8'h1c, 32'd255, 1'b0);
      wr_chk(8'h20, 32'd255, 1'b0);
      wr_chk(8'h00, 32'd11, 1'b0);
      rd_chk(8'h2c, 32'd1);
      wr_chk(8'h2c, 32'd0, 1'b0);
      rd_chk(8'h2c, 32'd1);
      wr_chk(8'h24, 32'd20000, 1'b0);
      wr_chk(8'h28, 32'd20000, 1'b0);
      req_spd_mv <= 16'sd200;
      req_trq_mv <= -16'sd200;
      repeat (100) @(posedge pclk);
      chk(speed_cmd, 32'h0);
      chk(torque_cmd, 32'h0);
      req_spd_mv <= 16'sd5000;
      req_trq_mv <= 16'sd5000;
      repeat (600) @(posedge pclk);
      chk(speed_cmd, 32'd25000);
      chk(speed_limit, 32'd25000);
      chk(torque_cmd, 32'd500);
      $display("analog mode done");
      wrap_up;
   end
endmodule
